// ==== jog_consts.svh ====
// Constants of the jog motion sequencer: offsets, reset values, timing.
// Assumes a 40 MHz sys_clk and a word-wide parameter port.
// How it works
// - Moves start from actual position, chosen direction
// - Slow and fast velocities, request picks one
// - Continuous method moves while request held
// - Short step request moves one step distance
// - Held step: step, wait, then continuous
// - Slow velocity 1..max, default 60, clamped
// - Fast velocity 1..max, default 180, clamped
// - Method 0 continuous, 1 step, default 1
// - Step distance min 1, default 20, latched
// - Wait 1..32767 ms, default 500, latched
// - Leave jog at standstill after halt/stop/error
// - Fault-free output for states 4, 5, 6
// - Active output only in state 6
// - Panel start enables stage, uses continuous
// - Panel offers four movements, confirm starts
// - Standstill window only in step method
`ifndef JOG_CONSTS_SVH
`define JOG_CONSTS_SVH
`define OFS_METHOD       16'h2906
`define OFS_SLOW_VEL     16'h2908
`define OFS_FAST_VEL     16'h290A
`define OFS_STEP_DIST    16'h290E
`define OFS_STEP_WAIT    16'h2910
`define RST_METHOD       16'h0001
`define RST_SLOW_VEL     32'h0000_003C
`define RST_FAST_VEL     32'h0000_00B4
`define RST_STEP_DIST    32'h0000_0014
`define RST_STEP_WAIT    16'h01F4
`define MAX_STEP_WAIT    16'h7FFF
`define MAX_U31          32'h7FFF_FFFF
`define CLK_HZ           40000000
`define MS_PER_S         1000
`define CYC_PER_MS       (`CLK_HZ / `MS_PER_S)
`define STATE_RDY_ON     4'h4
`define STATE_SW_ON      4'h5
`define STATE_OP_EN      4'h6
`endif

// ==== jog_pkg.sv ====
// Types shared by the jog motion sequencer.
// Assumes nothing beyond the constants header.
package jog_pkg;
  typedef enum logic [2:0] {JOG_IDLE, JOG_STEP, JOG_WAIT, JOG_CONT, JOG_STOP} jog_state_t;
endpackage : jog_pkg

// ==== jog_motion_sequencer.sv ====
// Jog sequencer: direction requests to velocity and step commands.
// Assumes a motion core that follows velocity/target commands and reports standstill.
`include "jog_consts.svh"
`timescale 1ns/1ps
module jog_motion_sequencer
  import jog_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `CYC_PER_MS
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        par_wr,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  input  wire logic        dir_pos,
  input  wire logic        dir_neg,
  input  wire logic        fast_sel,
  input  wire logic        jog_enable,
  input  wire logic        panel_confirm,
  input  wire logic [1:0]  panel_choice,
  input  wire logic [31:0] ramp_v_max,
  input  wire logic [31:0] actual_position,
  input  wire logic        motor_standstill,
  input  wire logic        stop_request,
  input  wire logic [3:0]  op_state,
  output logic             jog_active,
  output logic             power_enable,
  output logic             moving,
  output logic             move_negative,
  output logic [31:0]      velocity_cmd,
  output logic             step_move,
  output logic [31:0]      target_position,
  output logic             standstill_mon_en,
  output logic             fault_free_output,
  output logic             active_state_output
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Pin inputs through two flip-flops
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  always_ff @(posedge sys_clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      pin_s1_reg <= 5'h0_0;
      pin_s2_reg <= 5'h0_0;
    end
    else
    begin
      pin_s1_reg <= {dir_pos, dir_neg, fast_sel, panel_confirm, jog_enable};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic p_pos, p_neg, p_fast, p_conf, p_en;
  assign {p_pos, p_neg, p_fast, p_conf, p_en} = pin_s2_reg;

  function automatic logic [31:0] clamp_vel(input logic [31:0] v, input logic [31:0] vmax);
    clamp_vel = (v > vmax) ? vmax : v;
  endfunction : clamp_vel

  function automatic logic [31:0] limit_range(input logic [31:0] v, input logic [31:0] hi);
    limit_range = (v == 32'h0000_0000) ? 32'h0000_0001 : ((v > hi) ? hi : v);
  endfunction : limit_range

  // Parameter registers
  logic        method_reg, method_next;
  logic [31:0] slow_reg, slow_next, fast_reg, fast_next, dist_reg, dist_next;
  logic [15:0] wait_reg, wait_next;
  always_comb
  begin
    method_next = method_reg;
    slow_next   = slow_reg;
    fast_next   = fast_reg;
    dist_next   = dist_reg;
    wait_next   = wait_reg;
    if (par_wr)
    begin
      unique case (par_addr)
        `OFS_METHOD:    method_next = par_wdata[0];
        `OFS_SLOW_VEL:  slow_next   = limit_range(par_wdata, `MAX_U31);
        `OFS_FAST_VEL:  fast_next   = limit_range(par_wdata, `MAX_U31);
        `OFS_STEP_DIST: dist_next   = limit_range(par_wdata, `MAX_U31);
        `OFS_STEP_WAIT: wait_next   = 16'(limit_range(par_wdata, {16'h0000, `MAX_STEP_WAIT}));
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      method_reg <= 1'(`RST_METHOD);
      slow_reg   <= `RST_SLOW_VEL;
      fast_reg   <= `RST_FAST_VEL;
      dist_reg   <= `RST_STEP_DIST;
      wait_reg   <= `RST_STEP_WAIT;
    end
    else
    begin
      method_reg <= method_next;
      slow_reg   <= slow_next;
      fast_reg   <= fast_next;
      dist_reg   <= dist_next;
      wait_reg   <= wait_next;
    end
  end

  logic [31:0] rdata_next;
  always_comb
  begin
    unique case (par_addr)
      `OFS_METHOD:    rdata_next = {31'h0, method_reg};
      `OFS_SLOW_VEL:  rdata_next = slow_reg;
      `OFS_FAST_VEL:  rdata_next = fast_reg;
      `OFS_STEP_DIST: rdata_next = dist_reg;
      `OFS_STEP_WAIT: rdata_next = {16'h0000, wait_reg};
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  // Sequencer
  jog_state_t  st_reg, st_next;
  logic        panel_reg, panel_next, neg_reg, neg_next, fastl_reg, fastl_next;
  logic        conf_d_reg;
  logic [31:0] tgt_reg, tgt_next, ms_cnt_reg, ms_cnt_next;
  logic [15:0] wait_cnt_reg, wait_cnt_next, wait_lat_reg, wait_lat_next;
  logic        req_pos, req_neg, req_any, req_same, conf_edge, step_mode;

  assign conf_edge = p_conf & ~conf_d_reg;
  assign req_pos   = panel_reg ? (panel_choice[1] == 1'b0) : (p_pos & ~p_neg);
  assign req_neg   = panel_reg ? (panel_choice[1] == 1'b1) : (p_neg & ~p_pos);
  assign req_any   = panel_reg ? p_conf : (req_pos | req_neg);
  assign req_same  = req_any & (neg_reg ? req_neg : req_pos);
  assign step_mode = method_reg & ~panel_reg;

  always_comb
  begin
    st_next       = st_reg;
    panel_next    = panel_reg & (st_reg != JOG_IDLE);
    neg_next      = neg_reg;
    fastl_next    = fastl_reg;
    tgt_next      = tgt_reg;
    ms_cnt_next   = ms_cnt_reg;
    wait_cnt_next = wait_cnt_reg;
    wait_lat_next = wait_lat_reg;
    unique case (st_reg)
      JOG_IDLE:
      begin
        if (conf_edge && !stop_request)
        begin
          // Panel choice: bit 0 fast, bit 1 negative
          panel_next = 1'b1;
          neg_next   = panel_choice[1];
          fastl_next = panel_choice[0];
          st_next    = JOG_CONT;
        end
        else if (p_en && !stop_request && !panel_reg && (req_pos ^ req_neg))
        begin
          panel_next    = 1'b0;
          neg_next      = req_neg;
          fastl_next    = p_fast;
          wait_lat_next = wait_reg;
          tgt_next      = req_neg ? actual_position - dist_reg
                                  : actual_position + dist_reg;
          st_next       = method_reg ? JOG_STEP : JOG_CONT;
        end
      end
      JOG_STEP:
      begin
        if (stop_request)
          st_next = JOG_STOP;
        else if (actual_position == tgt_reg && motor_standstill)
        begin
          ms_cnt_next   = 32'h0000_0000;
          wait_cnt_next = 16'h0000;
          st_next       = req_same ? JOG_WAIT : JOG_IDLE;
        end
      end
      JOG_WAIT:
      begin
        if (stop_request)
          st_next = JOG_STOP;
        else if (!req_same)
          st_next = JOG_IDLE;
        else if (ms_cnt_reg == CYC_PER_MS - 1)
        begin
          ms_cnt_next   = 32'h0000_0000;
          wait_cnt_next = wait_cnt_reg + 16'h0001;
          if (wait_cnt_reg + 16'h0001 >= wait_lat_reg)
            st_next = JOG_CONT;
        end
        else
          ms_cnt_next = ms_cnt_reg + 32'h0000_0001;
      end
      JOG_CONT:
      begin
        if (stop_request)
          st_next = JOG_STOP;
        else if (!req_same)
          st_next = JOG_IDLE;
      end
      JOG_STOP:
      begin
        if (motor_standstill && !stop_request)
        begin
          st_next    = JOG_IDLE;
          panel_next = 1'b0;
        end
      end
    endcase
  end

  logic        moving_next, step_next, mon_next, ff_next, act_next, jog_next, pwr_next;
  logic [31:0] vel_next;
  always_comb
  begin
    moving_next = (st_next == JOG_STEP) || (st_next == JOG_CONT);
    step_next   = (st_next == JOG_STEP);
    vel_next    = moving_next ? clamp_vel(fastl_next ? fast_reg : slow_reg, ramp_v_max)
                              : 32'h0000_0000;
    mon_next    = step_mode && (st_next != JOG_IDLE);
    ff_next     = (op_state == `STATE_RDY_ON) || (op_state == `STATE_SW_ON)
               || (op_state == `STATE_OP_EN);
    act_next    = (op_state == `STATE_OP_EN);
    jog_next    = (st_next != JOG_IDLE) || p_en;
    pwr_next    = panel_next || p_en;
  end

  always_ff @(posedge sys_clk or negedge rst_s2_reg)
  begin
    if (!rst_s2_reg)
    begin
      st_reg              <= JOG_IDLE;
      panel_reg           <= 1'b0;
      neg_reg             <= 1'b0;
      fastl_reg           <= 1'b0;
      conf_d_reg          <= 1'b0;
      tgt_reg             <= 32'h0000_0000;
      ms_cnt_reg          <= 32'h0000_0000;
      wait_cnt_reg        <= 16'h0000;
      wait_lat_reg        <= `RST_STEP_WAIT;
      par_rdata           <= 32'h0000_0000;
      moving              <= 1'b0;
      move_negative       <= 1'b0;
      velocity_cmd        <= 32'h0000_0000;
      step_move           <= 1'b0;
      target_position     <= 32'h0000_0000;
      standstill_mon_en   <= 1'b0;
      fault_free_output   <= 1'b0;
      active_state_output <= 1'b0;
      jog_active          <= 1'b0;
      power_enable        <= 1'b0;
    end
    else
    begin
      st_reg              <= st_next;
      panel_reg           <= panel_next;
      neg_reg             <= neg_next;
      fastl_reg           <= fastl_next;
      conf_d_reg          <= p_conf;
      tgt_reg             <= tgt_next;
      ms_cnt_reg          <= ms_cnt_next;
      wait_cnt_reg        <= wait_cnt_next;
      wait_lat_reg        <= wait_lat_next;
      par_rdata           <= rdata_next;
      moving              <= moving_next;
      move_negative       <= neg_next;
      velocity_cmd        <= vel_next;
      step_move           <= step_next;
      target_position     <= tgt_next;
      standstill_mon_en   <= mon_next;
      fault_free_output   <= ff_next;
      active_state_output <= act_next;
      jog_active          <= jog_next;
      power_enable        <= pwr_next;
    end
  end
endmodule : jog_motion_sequencer

// ==== jog_motion_sequencer_assertions.sv ====
// Port checker for the jog sequencer.
// Assumes one sys_clk domain; bound onto the design top.
`timescale 1ns/1ps
module jog_motion_sequencer_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        dir_pos,
  input wire logic        dir_neg,
  input wire logic        panel_confirm,
  input wire logic [31:0] ramp_v_max,
  input wire logic        stop_request,
  input wire logic [3:0]  op_state,
  input wire logic        power_enable,
  input wire logic        moving,
  input wire logic        move_negative,
  input wire logic [31:0] velocity_cmd,
  input wire logic        step_move,
  input wire logic        fault_free_output,
  input wire logic        active_state_output
);
  logic [2:0] up_reg;
  logic [2:0] up_next;
  logic       up_ok;

  // Age since reset release, saturating
  always_comb
  begin
    up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      up_reg <= 3'h0;
    else
      up_reg <= up_next;
  end
  assign up_ok = (up_reg == 3'h7);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  fault_free_a: assert property (up_ok && $stable(op_state) [*3] |->
    fault_free_output == (op_state inside {4'h4, 4'h5, 4'h6})) else $error("fault free output wrong");
  active_out_a: assert property (up_ok && $stable(op_state) [*3] |->
    active_state_output == (op_state == 4'h6)) else $error("active output wrong");
  both_dirs_a: assert property ((up_ok && dir_pos && dir_neg && !panel_confirm) [*5] ##0 !moving
    |=> !moving) else $error("motion on both directions");
  stop_block_a: assert property ((up_ok && stop_request) [*4] ##0 !moving |=> !moving)
    else $error("start during stop");
  dir_hold_a: assert property (moving && $past(moving) |-> $stable(move_negative))
    else $error("direction changed mid move");
  vel_clamp_a: assert property (moving && $stable(ramp_v_max) |->
    velocity_cmd <= ramp_v_max && velocity_cmd != 32'h0000_0000) else $error("velocity out of range");
  step_move_a: assert property (step_move |-> moving) else $error("step without motion");
  power_on_a: assert property (moving |-> power_enable) else $error("motion without power");
endmodule : jog_motion_sequencer_assertions

bind jog_motion_sequencer jog_motion_sequencer_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .dir_pos(dir_pos), .dir_neg(dir_neg), .panel_confirm(panel_confirm),
  .ramp_v_max(ramp_v_max), .stop_request(stop_request), .op_state(op_state), .power_enable(power_enable),
  .moving(moving), .move_negative(move_negative), .velocity_cmd(velocity_cmd), .step_move(step_move),
  .fault_free_output(fault_free_output), .active_state_output(active_state_output)
);

// ==== jog_motor_model.sv ====
// Motion core stand-in: one position unit per clock.
// Assumes the sequencer's moving/step/target outputs.
`timescale 1ns/1ps
module jog_motor_model (
  input  wire logic        sys_clk,
  input  wire logic        moving,
  input  wire logic        move_negative,
  input  wire logic        step_move,
  input  wire logic [31:0] target_position,
  output logic      [31:0] actual_position,
  output logic             motor_standstill
);
  initial actual_position = 32'h0000_1000;
  assign motor_standstill = !moving || (step_move && actual_position == target_position);
  always @(posedge sys_clk)
    if (!motor_standstill)
      actual_position <= move_negative ? actual_position - 32'h1 : actual_position + 32'h1;
endmodule : jog_motor_model

// ==== jog_motion_sequencer_tb.sv ====
// Self-checking bench for the jog sequencer.
// Assumes the motor model on the far side and CYC_PER_MS of 4.
`include "jog_consts.svh"
`timescale 1ns/1ps
module jog_motion_sequencer_tb;
  logic sys_clk = 1'b0, rst_n, par_wr, dir_pos, dir_neg, fast_sel, jog_enable, panel_confirm;
  logic stop_request, motor_standstill, jog_active, power_enable, moving, move_negative;
  logic step_move, standstill_mon_en, fault_free_output, active_state_output;
  logic [15:0] par_addr;
  logic [31:0] par_wdata, par_rdata, ramp_v_max, actual_position, velocity_cmd, target_position;
  logic [31:0] slow, fast, p0, sdist;
  logic [3:0]  op_state;
  logic [1:0]  panel_choice;
  int          miscompares = 0, n_checks = 0, i, k;

  always #12.5 sys_clk = ~sys_clk;
  jog_motion_sequencer #(.CYC_PER_MS(4)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .par_wr(par_wr), .par_addr(par_addr), .par_wdata(par_wdata),
    .par_rdata(par_rdata), .dir_pos(dir_pos), .dir_neg(dir_neg), .fast_sel(fast_sel), .jog_enable(jog_enable),
    .panel_confirm(panel_confirm), .panel_choice(panel_choice), .ramp_v_max(ramp_v_max),
    .actual_position(actual_position), .motor_standstill(motor_standstill), .stop_request(stop_request),
    .op_state(op_state), .jog_active(jog_active), .power_enable(power_enable), .moving(moving),
    .move_negative(move_negative), .velocity_cmd(velocity_cmd), .step_move(step_move),
    .target_position(target_position), .standstill_mon_en(standstill_mon_en),
    .fault_free_output(fault_free_output), .active_state_output(active_state_output)
  );
  jog_motor_model u_motor (
    .sys_clk(sys_clk), .moving(moving), .move_negative(move_negative), .step_move(step_move),
    .target_position(target_position), .actual_position(actual_position), .motor_standstill(motor_standstill)
  );

  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge sys_clk) {par_wr, par_addr, par_wdata} = {1'b1, a, d};
    @(negedge sys_clk) par_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge sys_clk) par_addr = a;
    @(negedge sys_clk) chk(par_rdata, e);
  endtask : rd
  task automatic wait_mv(input logic v, input int lim);
    for (k = 0; k < lim && moving !== v; k++) @(negedge sys_clk);
    if (moving !== v)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : wait_mv
  function automatic logic [31:0] clampv(input logic [31:0] v);
    return (v > ramp_v_max) ? ramp_v_max : v;
  endfunction : clampv

  initial
  begin
    {par_wr, dir_pos, dir_neg, fast_sel, panel_confirm, stop_request, rst_n} = '0;
    {par_addr, par_wdata, panel_choice, jog_enable} = '0;
    ramp_v_max = 32'h0000_1000;
    op_state = 4'h6;
    void'($urandom(87837));
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    jog_enable = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd(`OFS_METHOD, `RST_METHOD);
    rd(`OFS_SLOW_VEL, `RST_SLOW_VEL);
    rd(`OFS_FAST_VEL, `RST_FAST_VEL);
    rd(`OFS_STEP_DIST, `RST_STEP_DIST);
    rd(`OFS_STEP_WAIT, `RST_STEP_WAIT);
    rd(16'h2904, 32'h0000_0000);
    wr(`OFS_SLOW_VEL, 32'h0000_0000);
    rd(`OFS_SLOW_VEL, 32'h0000_0001);
    wr(`OFS_STEP_WAIT, 32'h0000_9000);
    rd(`OFS_STEP_WAIT, `MAX_STEP_WAIT);
    slow = $urandom_range(1, 4000);
    fast = $urandom_range(1, 8000);
    wr(`OFS_SLOW_VEL, slow);
    wr(`OFS_FAST_VEL, fast);
    wr(`OFS_STEP_WAIT, 32'h0000_0003);
    sdist = $urandom_range(1, 30);
    wr(`OFS_STEP_DIST, sdist);
    // Short then held step request
    for (i = 0; i < 2; i++)
    begin
      p0 = actual_position;
      dir_pos = 1'b1;
      wait_mv(1'b1, 10);
      chk(target_position, p0 + sdist);
      chk(velocity_cmd, clampv(slow));
      chk({step_move, standstill_mon_en}, 2'b11);
      dir_pos = (i == 1);
      wait_mv(1'b0, 40);
      chk(actual_position, p0 + sdist);
      for (k = 0; k < 60 && moving !== 1'b1; k++) @(negedge sys_clk);
      chk(k >= 10 && k <= 16, i);
      chk(step_move, 1'b0);
      dir_pos = 1'b0;
      wait_mv(1'b0, 10);
    end
    wr(`OFS_METHOD, 32'h0000_0000);
    for (i = 0; i < 4; i++)
    begin
      {dir_neg, fast_sel} = i[1:0];
      dir_pos = !i[1];
      wait_mv(1'b1, 10);
      chk(move_negative, i[1]);
      chk(velocity_cmd, clampv(i[0] ? fast : slow));
      chk({step_move, standstill_mon_en}, 2'b00);
      repeat ($urandom_range(5, 30)) @(negedge sys_clk);
      chk(moving, 1'b1);
      {dir_pos, dir_neg} = 2'b00;
      wait_mv(1'b0, 10);
    end
    {dir_pos, dir_neg} = 2'b11;
    repeat (10) @(negedge sys_clk);
    chk(moving, 1'b0);
    dir_neg = 1'b0;
    wait_mv(1'b1, 10);
    stop_request = 1'b1;
    wait_mv(1'b0, 10);
    repeat (5) @(negedge sys_clk);
    chk(moving, 1'b0);
    chk(jog_active, 1'b1);
    // Let the pin synchronisers drain before the stop is lifted
    {dir_pos, jog_enable} = '0;
    repeat (3) @(negedge sys_clk);
    stop_request = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(jog_active, 1'b0);
    wr(`OFS_METHOD, 32'h0000_0001);
    for (i = 0; i < 4; i++)
    begin
      panel_choice = i[1:0];
      panel_confirm = 1'b1;
      wait_mv(1'b1, 10);
      chk({power_enable, step_move}, 2'b10);
      chk(move_negative, i[1]);
      chk(velocity_cmd, clampv(i[0] ? fast : slow));
      panel_confirm = 1'b0;
      wait_mv(1'b0, 10);
    end
    for (i = 0; i < 16; i++)
    begin
      op_state = i[3:0];
      repeat (4) @(negedge sys_clk);
      chk(fault_free_output, i inside {4, 5, 6});
      chk(active_state_output, i == 6);
    end
    report_and_stop();
  end
endmodule : jog_motion_sequencer_tb
